// ---- src/ric_pkg.sv ----
// Constants and carrier types for the reset and interrupt control block
`default_nettype none
package ric_pkg;
    // Power-on hold, in processor cycles from oscillator start
    localparam int POR_CYCLES = 4064;
    localparam int CLK_MHZ = 250;
    localparam int CYC_NS = 1000 / CLK_MHZ;
    // APB byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_TMR_ACK = 8'h08;
    localparam logic [7:0] A_SCI_ACK = 8'h0c;
    localparam logic [7:0] A_SPI_ACK = 8'h10;
    localparam logic [7:0] A_DDR = 8'h14;
    localparam logic [7:0] A_CORE = 8'h18;
    // Reset values, prescaler top, stack window and frame size
    localparam logic [15:0] TMR_RST = 16'hfffc;
    localparam logic [1:0] PRESC_RST = 2'h0;
    localparam logic [1:0] PRESC_TOP = 2'h3;
    localparam logic [7:0] SP_TOP = 8'hff;
    localparam logic [7:0] SP_BASE = 8'hc0;
    localparam logic [5:0] SP_LOW = 6'h3f;
    localparam logic [5:0] FRAME = 6'h05;
    localparam logic [23:0] DDR_RST = 24'h000000;
    // Vector pairs, low byte address
    localparam logic [12:0] VEC_RST = 13'h1ffe;
    localparam logic [12:0] VEC_SWI = 13'h1ffc;
    localparam logic [12:0] VEC_EXT = 13'h1ffa;
    localparam logic [12:0] VEC_TMR = 13'h1ff8;
    localparam logic [12:0] VEC_SCI = 13'h1ff6;
    localparam logic [12:0] VEC_SPI = 13'h1ff4;

    // Control bits, all clear after reset
    typedef struct packed {
        logic capture_irq_en;
        logic compare_irq_en;
        logic overflow_irq_en;
        logic compare_pin_level;
        logic tx_path_on;
        logic rx_path_on;
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic line_quiet_irq_en;
        logic receiver_wakeup;
        logic send_break;
        logic [1:0] baud_prescale_bits;
        logic sync_serial_on;
        logic sync_serial_irq_en;
        logic controller_select;
    } ric_ctl_t;
    localparam ric_ctl_t CTL_RST = 17'h00000;

    // Status flags, set by peripheral event pulses
    typedef struct packed {
        logic capture_flag;
        logic compare_flag;
        logic overflow_flag;
        logic tx_empty_flag;
        logic tx_done_flag;
        logic rx_full_flag;
        logic idle_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_error_flag;
        logic sync_transfer_done;
        logic write_collision_flag;
        logic mode_fault_flag;
    } ric_flg_t;
    localparam ric_flg_t FLG_RST = 13'h0300;
    localparam logic [12:0] TMR_MASK = 13'h1c00;
    localparam logic [12:0] SCI_MASK = 13'h03f8;
    localparam logic [12:0] SPI_MASK = 13'h0007;
endpackage
`default_nettype wire

// ---- src/ric_top.sv ----
// Reset sequencing, reset state and interrupt arbitration
// Operation
// - Power-on reset lasts 4064 cycles from oscillator start.
// - Reset pin still low after that delay keeps processor in reset.
// - Reset ends on first clock edge after reset pin rises.
// - Reset zeroes timer prescaler and loads counter with FFFC.
// - Reset clears compare output, pin level and timer enables.
// - Reset clears all port direction bits, making lines inputs.
// - Reset sets stack pointer to 00FF.
// - Reset selects restart vector 1FFE and sets interrupt mask.
// - Reset clears external, wait and stop latches.
// - Reset clears async serial enables, irq enables and status bits.
// - Reset disables sync serial, slave mode, clears its bits.
// - Reset sets transmit empty and transmit done flags.
// - Reset clears both baud prescale bits.
// - Four maskable sources plus unmasked software trap.
// - Cleared enable blocks request but flag still sets.
// - Flag clears after status access then associated register access.
// - Pending enabled request: stack, set mask, jump through vector.
// - Return restores stack; mask clears only if stacked copy zero.
// - Vectors: trap 1FFC, pin 1FFA, timer 1FF8, async 1FF6, sync 1FF4.
// - Each unit request is the OR of its enabled flags.
// - Masked pin event stays latched; cleared internal flag is lost.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ric_top #(
    parameter int POR_CYCLES = ric_pkg::POR_CYCLES
) (
    // Clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pins
    input wire logic ext_reset_n,
    input wire logic irq_pin_n,
    // Peripheral events and processor handshake
    input wire ric_pkg::ric_flg_t flag_set,
    input wire logic insn_boundary,
    input wire logic soft_trap,
    input wire logic return_from_trap,
    input wire logic stacked_mask,
    input wire logic wait_enter,
    input wire logic stop_enter,
    // Processor state
    output logic core_reset,
    output logic take_pulse,
    output logic [12:0] vector_addr,
    output logic irq_mask,
    output logic [7:0] stack_ptr,
    // Latches and unit state
    output logic ext_latch,
    output logic wait_latch,
    output logic stop_latch,
    output ric_pkg::ric_ctl_t ctl,
    output ric_pkg::ric_flg_t flags,
    output logic [23:0] port_dir,
    output logic [15:0] tmr_count,
    output logic [1:0] tmr_presc,
    output logic compare_output_pin
);
    if (POR_CYCLES < 1 || POR_CYCLES > 65535)
    begin : g_bad_por
        $error("POR_CYCLES out of range");
    end

    // Decode of the register that an address names
    function automatic logic is_at(input logic [7:0] a, input logic [7:0] r);
        is_at = (a == r);
    endfunction

    logic [15:0] por_cnt_r;
    logic por_done_r;
    logic hold;
    logic acc;
    logic wr;
    logic rd;
    logic [12:0] arm_r;
    logic [12:0] clr;
    logic irq_q_r;
    logic tmr_p;
    logic sci_p;
    logic spi_p;
    logic any_p;
    logic [5:0] sp_dn;
    logic [5:0] sp_up;

    // Power-on delay counts from oscillator start, i.e. rst_n release
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_cnt_r <= 16'h0000;
            por_done_r <= 1'b0;
        end
        else if (!por_done_r)
        begin
            por_cnt_r <= por_cnt_r + 16'h0001;
            por_done_r <= (por_cnt_r == 16'(POR_CYCLES - 1));
        end
    end

    // Pin low or power-on pending keeps all but the APB port and the pin sampler in reset
    assign hold = !por_done_r || !ext_reset_n;

    // Released on the first edge that samples the pin high
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            core_reset <= 1'b1;
        else
            core_reset <= hold;
    end

    // APB: setup edge registers answer, access phase completes in one cycle
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable)
            begin
                case (paddr)
                    ric_pkg::A_CTRL: prdata <= {15'h0000, ctl};
                    ric_pkg::A_STAT: prdata <= {19'h00000, flags};
                    ric_pkg::A_TMR_ACK: prdata <= {16'h0000, tmr_count};
                    ric_pkg::A_SCI_ACK: prdata <= 32'h00000000;
                    ric_pkg::A_SPI_ACK: prdata <= 32'h00000000;
                    ric_pkg::A_DDR: prdata <= {8'h00, port_dir};
                    ric_pkg::A_CORE: prdata <= {16'h0000, stop_latch,
                        wait_latch, ext_latch, irq_mask, 4'h0, stack_ptr};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Control bits; reset state wins over a write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ctl <= ric_pkg::CTL_RST;
        else if (hold)
            ctl <= ric_pkg::CTL_RST;
        else if (wr && is_at(paddr, ric_pkg::A_CTRL))
            ctl <= pwdata[16:0];
    end

    // Port direction bits, zero means input
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            port_dir <= ric_pkg::DDR_RST;
        else if (hold)
            port_dir <= ric_pkg::DDR_RST;
        else if (wr && is_at(paddr, ric_pkg::A_DDR))
            port_dir <= pwdata[23:0];
    end

    // Flags clear only after status read armed them, then the unit's
    // associated register was touched; a new event still wins the cycle
    always_comb
    begin
        clr = 13'h0000;
        if (acc && is_at(paddr, ric_pkg::A_TMR_ACK))
            clr = arm_r & ric_pkg::TMR_MASK;
        else if (acc && is_at(paddr, ric_pkg::A_SCI_ACK))
            clr = arm_r & ric_pkg::SCI_MASK;
        else if (acc && is_at(paddr, ric_pkg::A_SPI_ACK))
            clr = arm_r & ric_pkg::SPI_MASK;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            flags <= ric_pkg::FLG_RST;
        else if (hold)
            flags <= ric_pkg::FLG_RST;
        else
            flags <= (flags & ~clr) | flag_set;
    end

    // Arm records which flags were set when status was read
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            arm_r <= 13'h0000;
        else if (hold)
            arm_r <= 13'h0000;
        else if (rd && is_at(paddr, ric_pkg::A_STAT))
            arm_r <= flags;
        else
            arm_r <= arm_r & ~clr;
    end

    // Free-running timer, divide-by-four prescaler
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmr_presc <= ric_pkg::PRESC_RST;
            tmr_count <= ric_pkg::TMR_RST;
        end
        else if (hold)
        begin
            tmr_presc <= ric_pkg::PRESC_RST;
            tmr_count <= ric_pkg::TMR_RST;
        end
        else
        begin
            tmr_presc <= tmr_presc + 2'h1;
            if (tmr_presc == ric_pkg::PRESC_TOP)
                tmr_count <= tmr_count + 16'h0001;
        end
    end

    // Compare pin follows the programmed level on each compare event
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            compare_output_pin <= 1'b0;
        else if (hold)
            compare_output_pin <= 1'b0;
        else if (flag_set.compare_flag)
            compare_output_pin <= ctl.compare_pin_level;
    end

    // Unit requests; a disabled source never requests
    assign tmr_p = (flags.capture_flag && ctl.capture_irq_en)
        || (flags.compare_flag && ctl.compare_irq_en)
        || (flags.overflow_flag && ctl.overflow_irq_en);
    assign sci_p = (flags.tx_empty_flag && ctl.tx_empty_irq_en)
        || (flags.tx_done_flag && ctl.tx_done_irq_en)
        || ((flags.rx_full_flag || flags.overrun_flag)
            && ctl.rx_full_irq_en)
        || (flags.idle_flag && ctl.line_quiet_irq_en);
    assign spi_p = (flags.sync_transfer_done || flags.mode_fault_flag)
        && ctl.sync_serial_irq_en;
    assign any_p = ext_latch || tmr_p || sci_p || spi_p;

    // Pin falling edge is latched regardless of the mask
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_q_r <= 1'b1;
        else
            irq_q_r <= irq_pin_n;
    end

    // Latch cleared when its vector is taken; a new edge then wins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ext_latch <= 1'b0;
        else if (hold)
            ext_latch <= 1'b0;
        else if (irq_q_r && !irq_pin_n)
            ext_latch <= 1'b1;
        else if (take_pulse && vector_addr == ric_pkg::VEC_EXT)
            ext_latch <= 1'b0;
    end

    // Wait ends on any request; stop ends only on the pin event
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_latch <= 1'b0;
            stop_latch <= 1'b0;
        end
        else if (hold)
        begin
            wait_latch <= 1'b0;
            stop_latch <= 1'b0;
        end
        else
        begin
            wait_latch <= wait_enter || (wait_latch && !any_p);
            stop_latch <= stop_enter || (stop_latch && !ext_latch);
        end
    end

    // Stack of 64 bytes wraps inside the top page window
    assign sp_dn = stack_ptr[5:0] - ric_pkg::FRAME;
    assign sp_up = stack_ptr[5:0] + ric_pkg::FRAME;

    // Arbitration at instruction boundaries; return takes precedence
    // so that a frame is never pushed and popped in one cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            take_pulse <= 1'b0;
            vector_addr <= ric_pkg::VEC_RST;
            irq_mask <= 1'b1;
            stack_ptr <= ric_pkg::SP_TOP;
        end
        else if (hold)
        begin
            take_pulse <= 1'b0;
            vector_addr <= ric_pkg::VEC_RST;
            irq_mask <= 1'b1;
            stack_ptr <= ric_pkg::SP_TOP;
        end
        else
        begin
            take_pulse <= 1'b0;
            if (return_from_trap)
            begin
                irq_mask <= stacked_mask;
                stack_ptr <= ric_pkg::SP_BASE | {2'h0, sp_up};
            end
            else if (insn_boundary && (soft_trap || (!irq_mask && any_p)))
            begin
                take_pulse <= 1'b1;
                irq_mask <= 1'b1;
                stack_ptr <= ric_pkg::SP_BASE | {2'h0, sp_dn};
                if (soft_trap)
                    vector_addr <= ric_pkg::VEC_SWI;
                else if (ext_latch)
                    vector_addr <= ric_pkg::VEC_EXT;
                else if (tmr_p)
                    vector_addr <= ric_pkg::VEC_TMR;
                else if (sci_p)
                    vector_addr <= ric_pkg::VEC_SCI;
                else
                    vector_addr <= ric_pkg::VEC_SPI;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_por_hold_core: assert property (
        !por_done_r |=> core_reset)
        else $error("core left reset before power-on delay");
    a_pin_hold_core: assert property (
        !ext_reset_n |=> core_reset)
        else $error("core left reset while pin low");
    a_release_edge: assert property (
        $fell(core_reset) |-> $past(ext_reset_n) && $past(por_done_r))
        else $error("reset released without cause");
    a_timer_load: assert property (
        core_reset && por_done_r |-> tmr_count == ric_pkg::TMR_RST
            && tmr_presc == ric_pkg::PRESC_RST)
        else $error("timer not loaded in reset");
    a_state_reset: assert property (
        core_reset && por_done_r |-> stack_ptr == ric_pkg::SP_TOP
            && port_dir == ric_pkg::DDR_RST && ctl == ric_pkg::CTL_RST)
        else $error("reset state wrong");
    a_vec_restart: assert property (
        core_reset && por_done_r |-> vector_addr == ric_pkg::VEC_RST
            && irq_mask && flags == ric_pkg::FLG_RST)
        else $error("restart vector or mask wrong");
    a_take_masked: assert property (
        take_pulse && vector_addr != ric_pkg::VEC_SWI
            |-> !$past(irq_mask) && irq_mask)
        else $error("hardware vector taken while masked");
    a_rti_restore: assert property (
        return_from_trap && !hold |=> irq_mask == $past(stacked_mask))
        else $error("mask not restored from stack");
    a_pin_priority: assert property (
        take_pulse && vector_addr == ric_pkg::VEC_TMR
            |-> !$past(ext_latch))
        else $error("timer taken over pin");
    a_flag_set_wins: assert property (
        !hold |=> (flags & $past(flag_set)) == $past(flag_set))
        else $error("flag event lost");

    c_pin_take: cover property (take_pulse && vector_addr == ric_pkg::VEC_EXT);
    c_trap_take: cover property (take_pulse
        && vector_addr == ric_pkg::VEC_SWI);
    c_flag_clear: cover property ($fell(flags.compare_flag));
    c_release: cover property ($fell(core_reset));
endmodule // ric_top
`default_nettype wire

// ---- verification/ric_partner.sv ----
// Model of the reset source and the interrupt-raising peripherals
`timescale 1ns/1ps
`default_nettype none
module ric_partner (
    // Clock
    input wire logic clk_sys,
    // Pins and event pulses toward the block
    output logic ext_reset_n,
    output logic irq_pin_n,
    output ric_pkg::ric_flg_t flag_set
);
    // Power comes up with the reset pin held low
    initial
    begin
        ext_reset_n = 1'b0;
        irq_pin_n = 1'b1;
        flag_set = '0;
    end
    // Pin goes low and stays low two full cycles at least
    task automatic pin_drop();
        @(posedge clk_sys);
        ext_reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    // Reset pin back high from the next edge
    task automatic pin_release();
        @(posedge clk_sys);
        ext_reset_n <= 1'b1;
    endtask
    // Falling edge on the interrupt pin, held two cycles
    task automatic irq_fall();
        @(posedge clk_sys);
        irq_pin_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        irq_pin_n <= 1'b1;
    endtask
    // One-cycle event pulse on the chosen flags
    task automatic pulse(input ric_pkg::ric_flg_t f);
        @(posedge clk_sys);
        flag_set <= f;
        @(posedge clk_sys);
        flag_set <= '0;
    endtask
endmodule // ric_partner
`default_nettype wire

// ---- verification/reset_and_interrupt_control_test.sv ----
// Self-checking bench for the reset and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_control_test;
    // Short power-on count keeps the run brief
    localparam int POR = 8;
    localparam int LIMIT = 5000;
    typedef struct {
        logic [16:0] en;
        logic [12:0] evt;
        logic [7:0] ack;
        logic [12:0] vec;
    } ric_row_t;
    logic clk_sys, rst_n, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, rerr, ext_reset_n, irq_pin_n;
    ric_pkg::ric_flg_t flag_set, flags;
    ric_pkg::ric_ctl_t ctl;
    logic insn_boundary, soft_trap, return_from_trap, stacked_mask;
    logic wait_enter, stop_enter, core_reset, take_pulse, irq_mask;
    logic [12:0] vector_addr;
    logic [7:0] stack_ptr;
    logic ext_latch, wait_latch, stop_latch, compare_output_pin;
    logic [23:0] port_dir;
    logic [15:0] tmr_count;
    logic [1:0] tmr_presc;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    // Pin row has no flag event; the others pulse one flag of their unit
    ric_row_t rows [4] = '{
        '{17'h00000, 13'h0000, 8'h00, 13'h1ffa},
        '{17'h10000, 13'h1000, 8'h08, 13'h1ff8},
        '{17'h00100, 13'h0080, 8'h0c, 13'h1ff6},
        '{17'h00002, 13'h0004, 8'h10, 13'h1ff4}};

    ric_top #(.POR_CYCLES(POR)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n(ext_reset_n),
        .irq_pin_n(irq_pin_n), .flag_set(flag_set),
        .insn_boundary(insn_boundary), .soft_trap(soft_trap),
        .return_from_trap(return_from_trap), .stacked_mask(stacked_mask),
        .wait_enter(wait_enter), .stop_enter(stop_enter),
        .core_reset(core_reset), .take_pulse(take_pulse),
        .vector_addr(vector_addr), .irq_mask(irq_mask),
        .stack_ptr(stack_ptr), .ext_latch(ext_latch),
        .wait_latch(wait_latch), .stop_latch(stop_latch), .ctl(ctl),
        .flags(flags), .port_dir(port_dir), .tmr_count(tmr_count),
        .tmr_presc(tmr_presc), .compare_output_pin(compare_output_pin));
    ric_partner u_part (.clk_sys(clk_sys), .ext_reset_n(ext_reset_n),
        .irq_pin_n(irq_pin_n), .flag_set(flag_set));

    // Free-running clock, 4 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Hang guard: a stuck handshake still reaches the verdict
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer; waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Instruction boundary, optionally ending a trap instruction
    task automatic take(input logic trap, input logic [12:0] vec,
                        input logic hit);
        logic [7:0] sp0;
        @(posedge clk_sys);
        insn_boundary <= 1'b1;
        soft_trap <= trap;
        sp0 = stack_ptr;
        @(posedge clk_sys);
        insn_boundary <= 1'b0;
        soft_trap <= 1'b0;
        #1;
        chk(take_pulse, hit, "take");
        if (hit)
        begin
            chk(vector_addr, vec, "vector");
            chk(irq_mask, 1'b1, "mask set");
            chk(stack_ptr, {2'b11, sp0[5:0] - 6'd5}, "push");
        end
    endtask
    // Return instruction with the given stacked mask copy
    task automatic unmask(input logic m);
        logic [7:0] sp0;
        @(posedge clk_sys);
        return_from_trap <= 1'b1;
        stacked_mask <= m;
        sp0 = stack_ptr;
        @(posedge clk_sys);
        return_from_trap <= 1'b0;
        #1;
        chk(irq_mask, m, "mask restore");
        chk(stack_ptr, {2'b11, sp0[5:0] + 6'd5}, "pull");
    endtask
    // State that either reset forces
    task automatic rst_vals();
        chk(core_reset, 1'b1, "in reset");
        chk(tmr_count, 16'hfffc, "timer");
        chk(tmr_presc, 2'h0, "prescaler");
        chk(compare_output_pin, 1'b0, "compare pin");
        chk(port_dir, 24'h000000, "directions");
        chk(stack_ptr, 8'hff, "stack reset");
        chk(vector_addr, 13'h1ffe, "restart");
        chk(irq_mask, 1'b1, "mask reset");
        chk({ext_latch, wait_latch, stop_latch}, 3'h0, "latches");
        chk(ctl, 17'h00000, "controls");
        chk(flags, 13'h0300, "status");
    endtask

    initial
    begin
        {rst_n, psel, penable, pwrite, insn_boundary, soft_trap} = '0;
        {return_from_trap, stacked_mask, wait_enter, stop_enter} = '0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Power-on with the pin still low past the delay
        repeat (POR - 1) @(posedge clk_sys);
        #1;
        rst_vals();
        repeat (4) @(posedge clk_sys);
        #1;
        chk(core_reset, 1'b1, "pin holds");
        u_part.pin_release();
        #1;
        chk(core_reset, 1'b1, "before edge");
        @(posedge clk_sys);
        #1;
        chk(core_reset, 1'b0, "run");
        $display("power-on test done");
        // Each maskable source in turn, then the flag clear sequence of each peripheral unit
        foreach (rows[i])
        begin
            apb(1'b1, ric_pkg::A_CTRL, {15'h0, rows[i].en});
            if (rows[i].evt == '0)
                u_part.irq_fall();
            else
                u_part.pulse(rows[i].evt);
            #1;
            chk({ext_latch, flags & rows[i].evt}, {rows[i].evt == '0,
                rows[i].evt}, "raised");
            unmask(1'b0);
            take(1'b0, rows[i].vec, 1'b1);
            if (rows[i].evt != '0)
            begin
                apb(1'b0, rows[i].ack, 32'h0);
                #1;
                chk(flags & rows[i].evt, rows[i].evt, "no arm");
                apb(1'b0, ric_pkg::A_STAT, 32'h0);
                apb(1'b1, rows[i].ack, 32'h0);
                #1;
                chk(flags & rows[i].evt, 13'h0, "cleared");
            end
            apb(1'b1, ric_pkg::A_CTRL, 32'h0);
            $display("source row %0d done", i);
        end
        // Enable clear: flag sets, no request
        u_part.pulse(13'h0400);
        #1;
        chk(flags & 13'h0400, 13'h0400, "flag sets");
        unmask(1'b0);
        take(1'b0, 13'h0, 1'b0);
        unmask(1'b1);
        // Pin and timer both pending while masked: pin first
        apb(1'b1, ric_pkg::A_CTRL, 32'h00014000);
        u_part.irq_fall();
        take(1'b0, 13'h0, 1'b0);
        unmask(1'b0);
        take(1'b0, 13'h1ffa, 1'b1);
        unmask(1'b0);
        take(1'b0, 13'h1ff8, 1'b1);
        // Timer flag cleared while masked is lost
        apb(1'b0, ric_pkg::A_STAT, 32'h0);
        apb(1'b0, ric_pkg::A_TMR_ACK, 32'h0);
        unmask(1'b0);
        take(1'b0, 13'h0, 1'b0);
        unmask(1'b1);
        take(1'b1, 13'h1ffc, 1'b1);
        $display("priority test done");
        // Register access and an unmapped address
        apb(1'b1, ric_pkg::A_CTRL, 32'h0000387d);
        apb(1'b0, ric_pkg::A_CTRL, 32'h0);
        chk(rdat, 32'h0000387d, "ctrl back");
        apb(1'b1, ric_pkg::A_DDR, 32'h00ffffff);
        apb(1'b0, ric_pkg::A_DDR, 32'h0);
        chk(rdat, 32'h00ffffff, "ddr back");
        apb(1'b0, 8'h1c, 32'h0);
        chk(rerr, 1'b1, "unmapped error");
        chk(rdat, 32'h00000000, "unmapped data");
        @(posedge clk_sys);
        wait_enter <= 1'b1;
        stop_enter <= 1'b1;
        @(posedge clk_sys);
        wait_enter <= 1'b0;
        stop_enter <= 1'b0;
        #1;
        chk({wait_latch, stop_latch}, 2'h3, "low power");
        // Compare event drives the programmed level onto the pin
        u_part.pulse(13'h0800);
        #1;
        chk(compare_output_pin, 1'b1, "compare level");
        // Pin event wakes both low-power latches; the mask keeps it pending
        u_part.irq_fall();
        #1;
        chk({ext_latch, wait_latch, stop_latch}, 3'h4, "wake");
        // Pin reset mid-run restores every reset value
        u_part.pin_drop();
        #1;
        rst_vals();
        u_part.pin_release();
        @(posedge clk_sys);
        #1;
        chk(core_reset, 1'b0, "pin run");
        $display("pin reset test done");
        // Second power-on with the pin high: exact hold length
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (POR) @(posedge clk_sys);
        #1;
        chk(core_reset, 1'b1, "por hold");
        @(posedge clk_sys);
        #1;
        chk(core_reset, 1'b0, "por end");
        $display("second power-on test done");
        stop_test();
    end
endmodule // reset_and_interrupt_control_test
`default_nettype wire
